//--- hdl/lkt_regs.svh
// Register offsets, field positions, reset values and sequence codes of the legacy input trap.
// Assumes inclusion by bare name from every design file that needs these constants.
// Notes on behaviour
// - Each host function owns its control register copy.
// - Enables OR across functions; status bits shared.
// - Pass-through end sets bit 15 regardless.
// - Write one clears shared status; zero ignored.
// - Port trap status sets without its enable.
// - Bit 13 gates PCI interrupt; resets one.
// - Bit 12 shows raw controller interrupt.
// - Bit 12 ignores writes; clear at source.
// - Port 64h write sets bit 11.
// - Pass-through 64h writes skip write status.
// - Port 64h read sets bit 10.
// - Port 60h write sets bit 9.
// - Set enable makes matching status raise SMI.
// - Bit 4 makes controller interrupt raise SMI.
// - Bit 5 passes gate sequence without write status.
`ifndef LKT_REGS_SVH
`define LKT_REGS_SVH

`define LKT_NUM_FN          3
`define LKT_ADDR_W          12
// Byte address of the control register copy of function f is BASE + f * STRIDE.
`define LKT_CTRL_BASE       12'h0c0
`define LKT_CTRL_STRIDE     12'h100
`define LKT_INT_STATUS_OFS  12'h000
`define LKT_INT_MASK_OFS    12'h004

`define LKT_CTRL_RESET      16'h2000
`define LKT_CTRL_WMASK      8'hbf
`define LKT_BIT_END_STS     15
`define LKT_BIT_PCI_GATE    13
`define LKT_BIT_USB_STS     12
`define LKT_BIT_CMD_WR_STS  11
`define LKT_BIT_CMD_RD_STS  10
`define LKT_BIT_DAT_WR_STS  9
`define LKT_BIT_DAT_RD_STS  8
`define LKT_BIT_END_EN      7
`define LKT_BIT_BUSY        6
`define LKT_BIT_BYPASS_EN   5
`define LKT_BIT_USB_EN      4

// Interrupt status and mask layout.
`define LKT_INT_W           6
`define LKT_INT_END         0
`define LKT_INT_CMD_WR      1
`define LKT_INT_CMD_RD      2
`define LKT_INT_DAT_WR      3
`define LKT_INT_DAT_RD      4
`define LKT_INT_SMI         5

// Command codes of the gate pass-through sequence.
`define LKT_SEQ_OPEN_CMD    8'hd1
`define LKT_SEQ_CLOSE_CMD   8'hff

`endif

//--- hdl/lkt_pkg.sv
// Types shared by the legacy input trap design files.
// Assumes nothing of its surroundings.
package lkt_pkg;

  // Progress through the gate pass-through write sequence.
  typedef enum logic [1:0] {
    LKT_SEQ_IDLE,
    LKT_SEQ_WAIT_DATA,
    LKT_SEQ_WAIT_CLOSE
  } lkt_seq_type;

endpackage : lkt_pkg

//--- hdl/lkt_fn_ctrl.sv
// Per-function part of the legacy input trap control register.
// Assumes write strobe and data come from the bus slave on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lkt_regs.svh"

module lkt_fn_ctrl
  import lkt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  input  wire logic        usb_irq,
  output logic      [7:0]  enables,
  output logic             pci_gate,
  output logic             pci_irq
);

  // Enable bits and the PCI gate are private to this function; bit 6 is not stored.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enables  <= 8'(`LKT_CTRL_RESET); // Low byte of the reset value.
      pci_gate <= 1'(`LKT_CTRL_RESET >> `LKT_BIT_PCI_GATE);
    end else if (wr_en) begin
      enables  <= wdata[7:0] & `LKT_CTRL_WMASK;
      pci_gate <= wdata[`LKT_BIT_PCI_GATE];
    end
  end

  // The controller interrupt reaches PCI only while the gate is open.
  assign pci_irq = usb_irq & pci_gate;

endmodule : lkt_fn_ctrl
`default_nettype wire

//--- hdl/lkt_trap.sv
// Legacy keyboard and mouse trap logic shared by three host functions, with an APB slave.
// Assumes host legacy port cycles arrive as one-cycle strobes on CLK, and that the
// controller interrupt requests are levels on CLK.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lkt_regs.svh"

module lkt_trap
  import lkt_pkg::*;
(
  input  wire logic                     CLK,
  input  wire logic                     NRST,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [`LKT_ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire logic                     IO_STB,
  input  wire logic                     IO_WR,
  input  wire logic                     IO_PORT64,
  input  wire logic [7:0]               IO_DATA,
  input  wire logic [`LKT_NUM_FN-1:0]   USB_IRQ,
  output logic      [`LKT_NUM_FN-1:0]   PCI_IRQ,
  output logic                          SMI_REQ,
  output logic                          IRQ
);

  localparam int NF = `LKT_NUM_FN;

  // Bus phase decode.
  wire logic setup_rd  = PSEL & ~PENABLE;
  wire logic access_wr = PSEL & PENABLE & PWRITE;

  // Address decode: one control register copy per function plus interrupt registers.
  logic [NF-1:0] hit_fn;
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_hit
      assign hit_fn[g] = (PADDR == `LKT_CTRL_BASE + `LKT_ADDR_W'(g) * `LKT_CTRL_STRIDE);
    end
  endgenerate
  wire logic hit_ists = (PADDR == `LKT_INT_STATUS_OFS);
  wire logic hit_imsk = (PADDR == `LKT_INT_MASK_OFS);
  wire logic hit_any  = (|hit_fn) | hit_ists | hit_imsk;

  // Writes to each function copy, and a write from any copy for the shared status.
  wire logic [NF-1:0] wr_fn    = hit_fn & {NF{access_wr}};
  wire logic          wr_any   = |wr_fn;
  wire logic          wr_ists  = access_wr & hit_ists;
  wire logic          wr_imsk  = access_wr & hit_imsk;

  // Per-function register state.
  logic [7:0]    en_fn [NF];
  logic [NF-1:0] gate_fn;

  generate
    for (g = 0; g < NF; g++) begin : g_fn
      lkt_fn_ctrl u_fn (
        .clk      (CLK),
        .nrst     (NRST),
        .wr_en    (wr_fn[g]),
        .wdata    (PWDATA[15:0]),
        .usb_irq  (USB_IRQ[g]),
        .enables  (en_fn[g]),
        .pci_gate (gate_fn[g]),
        .pci_irq  (PCI_IRQ[g])
      );
    end
  endgenerate

  // Enables combine by OR across all functions.
  logic [7:0] en_or;
  always_comb begin
    en_or = 8'h00;
    for (int i = 0; i < NF; i++) begin
      en_or = en_or | en_fn[i];
    end
  end

  wire logic bypass_en = en_or[`LKT_BIT_BYPASS_EN];

  // Legacy port cycle classification.
  wire logic cyc_cmd_wr = IO_STB & IO_WR & IO_PORT64;
  wire logic cyc_cmd_rd = IO_STB & ~IO_WR & IO_PORT64;
  wire logic cyc_dat_wr = IO_STB & IO_WR & ~IO_PORT64;
  wire logic cyc_dat_rd = IO_STB & ~IO_WR & ~IO_PORT64;

  // Gate pass-through sequencer: open command, data byte, close command.
  lkt_seq_type seq;
  lkt_seq_type next_seq;
  logic        seq_absorb;
  logic        seq_end;

  always_comb begin
    next_seq   = seq;
    seq_absorb = 1'b0;
    seq_end    = 1'b0;
    if (!bypass_en) begin
      next_seq = LKT_SEQ_IDLE;
    end else begin
      case (seq)
        LKT_SEQ_IDLE: begin
          if (cyc_cmd_wr && IO_DATA == `LKT_SEQ_OPEN_CMD) begin
            next_seq   = LKT_SEQ_WAIT_DATA;
            seq_absorb = 1'b1;
          end
        end
        LKT_SEQ_WAIT_DATA: begin
          if (cyc_dat_wr) begin
            next_seq   = LKT_SEQ_WAIT_CLOSE;
            seq_absorb = 1'b1;
          end else if (IO_STB) begin
            next_seq = LKT_SEQ_IDLE;
          end
        end
        LKT_SEQ_WAIT_CLOSE: begin
          if (cyc_cmd_wr && IO_DATA == `LKT_SEQ_CLOSE_CMD) begin
            next_seq   = LKT_SEQ_IDLE;
            seq_absorb = 1'b1;
            seq_end    = 1'b1;
          end else if (IO_STB) begin
            next_seq = LKT_SEQ_IDLE;
          end
        end
        default: begin
          next_seq = LKT_SEQ_IDLE;
        end
      endcase
    end
  end

  // Sequencer state register.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      seq <= LKT_SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  wire logic seq_busy = (seq != LKT_SEQ_IDLE);

  // Trap events; an absorbed sequence write leaves the write status alone.
  wire logic ev_end    = seq_end;
  wire logic ev_cmd_wr = cyc_cmd_wr & ~seq_absorb;
  wire logic ev_cmd_rd = cyc_cmd_rd;
  wire logic ev_dat_wr = cyc_dat_wr & ~seq_absorb;
  wire logic ev_dat_rd = cyc_dat_rd;

  // Shared status: bit 15 and bits 11..8 in that order.
  wire logic [4:0] ev_vec  = {ev_end, ev_cmd_wr, ev_cmd_rd, ev_dat_wr, ev_dat_rd};
  wire logic [4:0] clr_vec = {PWDATA[`LKT_BIT_END_STS], PWDATA[11:8]} & {5{wr_any}};
  logic      [4:0] trap_sts;

  // Set wins over a clear in the same cycle; status sets with or without its enable.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      trap_sts <= 5'h00;
    end else begin
      trap_sts <= (trap_sts & ~clr_vec) | ev_vec;
    end
  end

  // SMI request: each status bit against its OR-combined enable, plus controller interrupts.
  wire logic [4:0] trap_en = {en_or[`LKT_BIT_END_EN], en_or[3:0]};
  wire logic       usb_smi = (|USB_IRQ) & en_or[`LKT_BIT_USB_EN];
  wire logic       smi_now = (|(trap_sts & trap_en)) | usb_smi;
  assign SMI_REQ = smi_now;

  // Interrupt status, mask and level output.
  logic [`LKT_INT_W-1:0] int_sts;
  logic [`LKT_INT_W-1:0] int_msk;
  logic                  smi_last;
  wire  logic            smi_rise = smi_now & ~smi_last;
  wire  logic [`LKT_INT_W-1:0] int_ev  = {smi_rise, ev_dat_rd, ev_dat_wr,
                                          ev_cmd_rd, ev_cmd_wr, ev_end};
  wire  logic [`LKT_INT_W-1:0] int_clr = PWDATA[`LKT_INT_W-1:0] & {`LKT_INT_W{wr_ists}};

  // Sticky bits cleared by writing one; a new event in the same cycle wins.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      int_sts  <= '0;
      int_msk  <= '0;
      smi_last <= 1'b0;
    end else begin
      int_sts  <= (int_sts & ~int_clr) | int_ev;
      smi_last <= smi_now;
      if (wr_imsk) begin
        int_msk <= PWDATA[`LKT_INT_W-1:0];
      end
    end
  end

  assign IRQ = |(int_sts & int_msk);

  // Read view of each function copy; bit 12 is this function's raw interrupt, write ignored.
  logic [15:0] ctrl_view [NF];
  generate
    for (g = 0; g < NF; g++) begin : g_view
      assign ctrl_view[g] = {trap_sts[4], 1'b0, gate_fn[g], USB_IRQ[g],
                             trap_sts[3:0], en_fn[g][7], seq_busy, en_fn[g][5:0]};
    end
  endgenerate

  // Read data multiplexer.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NF; i++) begin
      if (hit_fn[i]) begin
        rd_mux = {16'h0000, ctrl_view[i]};
      end
    end
    if (hit_ists) begin
      rd_mux = {{(32-`LKT_INT_W){1'b0}}, int_sts};
    end else if (hit_imsk) begin
      rd_mux = {{(32-`LKT_INT_W){1'b0}}, int_msk};
    end
  end

  // Read data and error are captured in the setup cycle and shown in the access phase.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_rd) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= ~hit_any;
    end
  end

  // Every access completes in its first access cycle.
  assign PREADY = 1'b1;

endmodule : lkt_trap
`default_nettype wire

//--- verification/lkt_trap_sva.sv
// Concurrent checks on the legacy input trap, watching only its top-level ports.
// Assumes it is bound into lkt_trap and that CLK and NRST are that block's clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "lkt_regs.svh"

module lkt_trap_sva
  import lkt_pkg::*;
(
  input wire logic                   CLK,
  input wire logic                   NRST,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [`LKT_ADDR_W-1:0] PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PSLVERR,
  input wire logic                   IO_STB,
  input wire logic                   IO_WR,
  input wire logic                   IO_PORT64,
  input wire logic [`LKT_NUM_FN-1:0] USB_IRQ,
  input wire logic [`LKT_NUM_FN-1:0] PCI_IRQ,
  input wire logic                   SMI_REQ,
  input wire logic                   IRQ
);
  // Access phase to one of the three control copies, and that copy's raw request.
  wire logic ctl = PSEL && PENABLE && PADDR[7:0] == 8'hc0 && PADDR[11:8] < 4'h3;
  wire logic raw = USB_IRQ[PADDR[9:8]];
  logic      rd_seen;

  // Tracks whether a port 64h read is pending since the last clear; set wins.
  always_ff @(posedge CLK) begin
    if (!NRST || (ctl && PWRITE && PWDATA[10] && !(IO_STB && !IO_WR && IO_PORT64))) begin
      rd_seen <= 1'b0;
    end else if (IO_STB && !IO_WR && IO_PORT64) begin
      rd_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_pci_gate; (PCI_IRQ & ~USB_IRQ) == '0; endproperty
  a_pci_gate: assert property (p_pci_gate) else $error("PCI request without source");
  property p_gate_reset; $rose(NRST) |-> PCI_IRQ == USB_IRQ; endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gate not open after reset");
  property p_quiet_reset; $rose(NRST) |-> !SMI_REQ && !IRQ; endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("request after reset");
  property p_ctl_upper; ctl && !PWRITE |-> PRDATA[31:16] == 16'h0000 && !PRDATA[14]; endproperty
  a_ctl_upper: assert property (p_ctl_upper) else $error("reserved bits set");
  property p_raw_irq; ctl && !PWRITE |-> PRDATA[12] == $past(raw); endproperty
  a_raw_irq: assert property (p_raw_irq) else $error("raw interrupt bit wrong");
  property p_rd_trap; ctl && !PWRITE |-> PRDATA[10] == $past(rd_seen); endproperty
  a_rd_trap: assert property (p_rd_trap) else $error("port read status wrong");
  property p_unmapped; PSEL && PENABLE && PADDR == 12'h008 |-> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; ctl |-> !PSLVERR; endproperty
  a_mapped: assert property (p_mapped) else $error("control copy refused");

  c_unmapped: cover property (PSEL && PENABLE && PSLVERR);
  c_smi: cover property ($rose(SMI_REQ));
  c_irq: cover property ($rose(IRQ));
endmodule : lkt_trap_sva

bind lkt_trap lkt_trap_sva chk_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .IO_STB(IO_STB), .IO_WR(IO_WR), .IO_PORT64(IO_PORT64), .USB_IRQ(USB_IRQ),
  .PCI_IRQ(PCI_IRQ), .SMI_REQ(SMI_REQ), .IRQ(IRQ));
`default_nettype wire

//--- verification/lkt_host_model.sv
// Host-side model that issues legacy port cycles to the trap block.
// Assumes it shares the trap's clock and is driven by the bench through its tasks.
`timescale 1ns/1ps
`default_nettype none

module lkt_host_model (
  input  wire logic       clk,
  output logic            io_stb,
  output logic            io_wr,
  output logic            io_p64,
  output logic      [7:0] io_data
);
  // Lines start idle at a known level.
  initial begin
    io_stb = 1'b0;
    io_wr = 1'b0;
    io_p64 = 1'b0;
    io_data = 8'h00;
  end

  // One port cycle with the strobe high for one clock; idle lines then show the inverse.
  task cycle(input logic w, input logic p64, input logic [7:0] d);
    @(posedge clk);
    io_stb <= 1'b1;
    io_wr <= w;
    io_p64 <= p64;
    io_data <= d;
    @(posedge clk);
    io_stb <= 1'b0;
    io_wr <= ~w;
    io_p64 <= ~p64;
    io_data <= ~d;
    #1;
  endtask : cycle

  // The recognised gate write sequence: command open, data, command close.
  task gate_seq;
    cycle(1'b1, 1'b1, 8'hd1);
    cycle(1'b1, 1'b0, 8'h5a);
    cycle(1'b1, 1'b1, 8'hff);
  endtask : gate_seq
endmodule : lkt_host_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the legacy input trap: APB register tasks and one task per scenario.
// Assumes the host model drives the legacy port strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [11:0] F0 = 12'h0c0;
  localparam logic [11:0] F1 = 12'h1c0;
  localparam logic [11:0] F2 = 12'h2c0;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  usb_irq = 3'b000;
  logic [31:0] prdata, rd;
  logic [2:0]  pci_irq;
  logic [7:0]  io_data;
  logic        pready, pslverr, io_stb, io_wr, io_p64, smi_req, irq, err;
  int          err_count = 0;
  int          cmp_count = 0;

  // Clock of 20 ns period.
  always #10 clk = ~clk;

  lkt_trap dut_u (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IO_STB(io_stb), .IO_WR(io_wr), .IO_PORT64(io_p64), .IO_DATA(io_data),
    .USB_IRQ(usb_irq), .PCI_IRQ(pci_irq), .SMI_REQ(smi_req), .IRQ(irq));
  lkt_host_model host_u (.clk(clk), .io_stb(io_stb), .io_wr(io_wr), .io_p64(io_p64),
    .io_data(io_data));

  task stop_test;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits for PREADY under a bound, then lets outputs settle.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("unexpected pready: expected 1 seen %b", pready);
      err_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task t_reset;
    apb(0, F0, 0); chk("ctrl0 reset", 32'h2000, rd);
    apb(0, F2, 0); chk("ctrl2 reset", 32'h2000, rd);
    apb(0, 12'h004, 0); chk("mask reset", 32'h0, rd);
    apb(0, 12'h008, 0); chk("unmapped err", 32'h1, err);
  endtask : t_reset

  task t_traps;
    host_u.cycle(0, 1, 8'h00);
    host_u.cycle(1, 0, 8'h11);
    host_u.cycle(1, 1, 8'h22);
    host_u.cycle(0, 0, 8'h00);
    apb(0, F2, 0); chk("trap status", 32'h2f00, rd);
    chk("smi disabled", 32'h0, smi_req);
    apb(1, F1, 32'h2008); chk("smi enabled", 32'h1, smi_req);
    apb(1, F0, 32'h2000); apb(0, F1, 0); chk("write zero", 32'h2f08, rd);
    apb(1, F0, 32'h2f00); apb(0, F1, 0); chk("w1c", 32'h2008, rd);
    chk("smi cleared", 32'h0, smi_req);
    apb(1, F1, 32'h2000);
  endtask : t_traps

  task t_seq;
    apb(1, F0, 32'h2020);
    host_u.gate_seq();
    apb(0, F1, 0); chk("seq end", 32'ha000, rd);
    chk("seq no smi", 32'h0, smi_req);
    apb(1, F2, 32'h2080); chk("end smi", 32'h1, smi_req);
    apb(1, F2, 32'ha000); chk("end cleared", 32'h0, smi_req);
    host_u.cycle(1, 1, 8'hd1);
    apb(0, F2, 0); chk("seq busy", 32'h2040, rd);
    host_u.cycle(0, 1, 8'h00);
    host_u.cycle(1, 1, 8'hff);
    apb(0, F1, 0); chk("aborted seq", 32'h2c00, rd);
    apb(1, F0, 32'h2e00);
  endtask : t_seq

  task t_usb;
    @(posedge clk) usb_irq <= 3'b010;
    #1;
    chk("pci pass", 32'h2, pci_irq);
    apb(0, F1, 0); chk("raw own", 32'h3000, rd);
    apb(0, F0, 0); chk("raw other", 32'h2000, rd);
    apb(1, F1, 32'h1000); chk("pci gated", 32'h0, pci_irq);
    apb(0, F1, 0); chk("raw ungated", 32'h1000, rd);
    chk("usb smi off", 32'h0, smi_req);
    apb(1, F1, 32'h0010); chk("usb smi", 32'h1, smi_req);
    @(posedge clk) usb_irq <= 3'b000;
    #1;
    chk("usb smi gone", 32'h0, smi_req);
    apb(0, F1, 0); chk("raw gone", 32'h0010, rd);
    apb(1, F1, 32'h2000);
  endtask : t_usb

  task t_int;
    apb(1, 12'h000, 32'h3f); apb(0, 12'h000, 0); chk("int clear", 32'h0, rd);
    apb(1, 12'h004, 32'h04); host_u.cycle(0, 1, 8'h00); chk("irq raised", 32'h1, irq);
    apb(0, 12'h000, 0); chk("int status", 32'h04, rd);
    apb(1, 12'h000, 32'h04); chk("irq cleared", 32'h0, irq);
    apb(1, 12'h004, 32'h0); host_u.cycle(0, 1, 8'h00); chk("irq masked", 32'h0, irq);
    apb(1, F0, 32'h2004); chk("smi on", 32'h1, smi_req);
    apb(0, 12'h000, 0); chk("smi rise", 32'h24, rd);
    apb(1, F0, 32'h2400); chk("smi off", 32'h0, smi_req);
  endtask : t_int

  // Reset in mid-run after the registers were changed, then the reset values again.
  task t_rst2;
    apb(1, F1, 32'h00bf);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(0, F1, 0); chk("ctrl1 rerun", 32'h2000, rd);
    apb(0, 12'h000, 0); chk("int rerun", 32'h0, rd);
    apb(0, 12'h004, 0); chk("mask rerun", 32'h0, rd);
  endtask : t_rst2

  // Reset for 20 clocks, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_traps();
    t_seq();
    t_usb();
    t_int();
    t_rst2();
    stop_test();
  end
endmodule : tb
`default_nettype wire
